/* File: common/cos_pkg.sv */
// Shared constants and types for the change-of-state input port
package cos_pkg;
  // ==========================================================
  // Widths and reset values
  localparam int          PORT_WIDTH    = 8;
  localparam logic [7:0]  CAPTURE_RESET = 8'h00;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  // Host strobe bundle: {port_select_n, read_strobe_n, source_select}
  localparam int          STROBE_WIDTH  = 3;
  localparam int          STB_SEL_N     = 2;
  localparam int          STB_RD_N      = 1;
  localparam int          STB_SRC       = 0;
  localparam logic [2:0]  STROBE_RESET  = 3'h6;
  // ==========================================================
  // Read source encoding on the select bit
  localparam logic        SRC_CAPTURED  = 1'b0;
  localparam logic        SRC_LIVE      = 1'b1;
  // ==========================================================
  // Host read cycle states
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_READ = 2'b10
  } read_state_t;
endpackage

/* File: verilog/cos_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module cos_sync #(
  parameter int               WIDTH       = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] stable_o
);
  // ==========================================================
  // Stages and filtered value
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] filtered;
  logic [WIDTH-1:0] next_filtered;

  // Per bit, accept a new level once stages two and three agree
  always_comb
  begin
    for (int b = 0; b < WIDTH; b++)
    begin
      next_filtered[b] = (stage2[b] == stage3[b]) ? stage3[b] : filtered[b];
    end
  end

  // Register the chain
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      stage1   <= RESET_VALUE;
      stage2   <= RESET_VALUE;
      stage3   <= RESET_VALUE;
      filtered <= RESET_VALUE;
    end
    else
    begin
      stage1   <= pin_i;
      stage2   <= stage1;
      stage3   <= stage2;
      filtered <= next_filtered;
    end
  end

  assign stable_o = filtered;
endmodule

/* File: verilog/change_of_state_input_port.sv */
// Change-of-state input port with interrupt and captured state
//
// Contract
// - Any monitored input differing from captured state flags a change.
// - A detected change sets the change interrupt latch toward the host.
// - Latch rising captures all eight monitored inputs into holding registers.
// - Select, read and source bit low put captured registers on the bus.
// - Reading captured state clears the latch unless another change happened.
// - Selected read with source bit high drives live input levels.
`timescale 1ns/100ps
module change_of_state_input_port #(
  parameter int WIDTH = cos_pkg::PORT_WIDTH
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] monitored_inputs_i,
  input  wire logic             port_select_n_i,
  input  wire logic             read_strobe_n_i,
  input  wire logic             source_select_bit_i,
  output logic      [WIDTH-1:0] host_data_bus_o,
  output logic                  host_data_bus_oe_o,
  output logic                  change_interrupt_o
);
  // Assertion clock and reset for this module
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // Synchronised pins
  logic [WIDTH-1:0]                 live;
  logic [cos_pkg::STROBE_WIDTH-1:0] strobes;
  logic                             selected;
  logic                             src_bit;

  // Monitored inputs
  cos_sync #(
    .WIDTH       (WIDTH),
    .RESET_VALUE ('0)
  ) u_input_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (monitored_inputs_i),
    .stable_o  (live)
  );

  // Host strobes, idle level at reset
  cos_sync #(
    .WIDTH       (cos_pkg::STROBE_WIDTH),
    .RESET_VALUE (cos_pkg::STROBE_RESET)
  ) u_strobe_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     ({port_select_n_i, read_strobe_n_i, source_select_bit_i}),
    .stable_o  (strobes)
  );

  // Decode a selected read
  assign selected = !strobes[cos_pkg::STB_SEL_N] &&
                    !strobes[cos_pkg::STB_RD_N];
  assign src_bit  = strobes[cos_pkg::STB_SRC];

  // ==========================================================
  // State
  cos_pkg::read_state_t state;
  cos_pkg::read_state_t next_state;
  logic                 read_src;
  logic                 next_read_src;
  logic [WIDTH-1:0]     captured;
  logic [WIDTH-1:0]     next_captured;
  logic                 int_latch;
  logic                 next_int_latch;
  logic [WIDTH-1:0]     data;
  logic [WIDTH-1:0]     next_data;
  logic                 mismatch;
  logic                 read_done;

  // Non-equality compare, both edge directions
  assign mismatch  = (live != captured);
  // End of a read of the captured registers
  assign read_done = (state == cos_pkg::ST_READ) && !selected &&
                     (read_src == cos_pkg::SRC_CAPTURED);

  // Read cycle sequencing and output data
  always_comb
  begin
    next_state    = state;
    next_read_src = read_src;
    unique case (state)
      cos_pkg::ST_IDLE:
      begin
        if (selected)
        begin
          next_state    = cos_pkg::ST_READ;
          next_read_src = src_bit;
        end
      end
      cos_pkg::ST_READ:
      begin
        if (!selected)
        begin
          next_state = cos_pkg::ST_IDLE;
        end
      end
    endcase
    // Source mux, captured or live
    if (next_read_src == cos_pkg::SRC_LIVE)
    begin
      next_data = live;
    end
    else
    begin
      next_data = captured;
    end
  end

  // Interrupt latch and capture
  always_comb
  begin
    next_int_latch = int_latch;
    next_captured  = captured;
    if (read_done)
    begin
      if (mismatch)
      begin
        // New change pending: latch stays, fresh capture
        next_int_latch = 1'b1;
        next_captured  = live;
      end
      else
      begin
        next_int_latch = 1'b0;
      end
    end
    else if (mismatch && !int_latch)
    begin
      next_int_latch = 1'b1;
      next_captured  = live;
    end
  end

  // Register all state
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state     <= cos_pkg::ST_IDLE;
      read_src  <= cos_pkg::SRC_CAPTURED;
      captured  <= cos_pkg::CAPTURE_RESET;
      int_latch <= 1'b0;
      data      <= cos_pkg::DATA_RESET;
    end
    else
    begin
      state     <= next_state;
      read_src  <= next_read_src;
      captured  <= next_captured;
      int_latch <= next_int_latch;
      data      <= next_data;
    end
  end

  // ==========================================================
  // Outputs
  assign host_data_bus_o    = data;
  assign host_data_bus_oe_o = (state == cos_pkg::ST_READ);
  assign change_interrupt_o = int_latch;

  // ==========================================================
  // Assertions
  a_change_sets_int: assert property (
    (mismatch && !int_latch && !read_done) |=> change_interrupt_o)
    else $error("Change did not raise the interrupt");

  a_int_needs_cause: assert property (
    $rose(change_interrupt_o) |-> $past(mismatch))
    else $error("Interrupt rose without an input change");

  a_capture_on_rise: assert property (
    $rose(int_latch) |-> (captured == $past(live)))
    else $error("Rising latch did not capture the inputs");

  a_read_captured: assert property (
    (state == cos_pkg::ST_READ && $past(state) == cos_pkg::ST_READ &&
     read_src == cos_pkg::SRC_CAPTURED)
    |-> (host_data_bus_o == $past(captured)))
    else $error("Captured read returned wrong data");

  a_read_clears: assert property (
    (read_done && !mismatch) |=> !change_interrupt_o)
    else $error("Read did not clear the interrupt");

  a_read_keeps: assert property (
    (read_done && mismatch) |=>
    (change_interrupt_o && captured == $past(live)))
    else $error("Pending change lost at end of read");

  a_read_live: assert property (
    (state == cos_pkg::ST_READ && $past(state) == cos_pkg::ST_READ &&
     read_src == cos_pkg::SRC_LIVE)
    |-> (host_data_bus_o == $past(live)))
    else $error("Live read returned wrong data");

  a_bus_released: assert property (
    (!selected ##1 !selected) |-> !host_data_bus_oe_o)
    else $error("Data bus driven outside a read");

  a_read_drives: assert property (
    (selected && state == cos_pkg::ST_IDLE) |=> host_data_bus_oe_o)
    else $error("Selected read did not drive the bus");

  c_change_int: cover property ($rose(change_interrupt_o));
  c_read_clear: cover property (read_done ##1 !change_interrupt_o);
  c_read_pending: cover property (read_done && mismatch);
  c_live_read: cover property (
    state == cos_pkg::ST_READ && read_src == cos_pkg::SRC_LIVE);
endmodule

/* File: test/host_model.sv */
// Host processor model issuing reads on the port
`timescale 1ns/100ps
module host_model (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] host_data_bus_i,
  input  wire logic       host_data_bus_oe_i,
  output logic            port_select_n_o,
  output logic            read_strobe_n_o,
  output logic            source_select_bit_o
);
  // Idle strobes from time zero
  initial
  begin
    port_select_n_o     = 1'b1;
    read_strobe_n_o     = 1'b1;
    source_select_bit_o = 1'b1;
  end
  // ==========================================================
  // Read cycle: strobes held until the bus is driven
  task automatic do_read(input logic src, output logic [7:0] d,
                         output logic ok);
    int n;
    begin
      n = 0;
      @(posedge ref_clk_i) #1;
      source_select_bit_o = src;
      port_select_n_o     = 1'b0;
      read_strobe_n_o     = 1'b0;
      while (host_data_bus_oe_i !== 1'b1 && n < 20)
      begin
        @(posedge ref_clk_i) #1;
        n++;
      end
      ok = host_data_bus_oe_i === 1'b1;
      d  = host_data_bus_i;
      // Hold the request through the edge that samples the enable
      @(posedge ref_clk_i) #1;
      port_select_n_o = 1'b1;
      read_strobe_n_o = 1'b1;
      // Release must reach the core before the next read
      repeat (9) @(posedge ref_clk_i);
      #1;
    end
  endtask
endmodule

/* File: test/change_of_state_input_port_tb.sv */
// Self-checking bench for the change-of-state input port
`timescale 1ns/100ps
module change_of_state_input_port_tb;
  logic       ref_clk_i;
  logic       rst_n_i;
  logic [7:0] mon;
  logic [7:0] dout;
  logic [7:0] bus;
  logic       oe;
  logic       irq;
  logic       sel_n;
  logic       rd_n;
  logic       src;
  logic [7:0] d;
  logic       ok;
  int         miscompares;
  int         n_tests;
  // ==========================================================
  // Design, host model and resolved bus
  change_of_state_input_port change_of_state_input_port_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .monitored_inputs_i(mon),
    .port_select_n_i(sel_n), .read_strobe_n_i(rd_n),
    .source_select_bit_i(src), .host_data_bus_o(dout),
    .host_data_bus_oe_o(oe), .change_interrupt_o(irq));
  host_model host_model_i (
    .ref_clk_i(ref_clk_i), .host_data_bus_i(bus),
    .host_data_bus_oe_i(oe), .port_select_n_o(sel_n),
    .read_strobe_n_o(rd_n), .source_select_bit_o(src));
  assign bus = oe ? dout : 8'hZZ;
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // ==========================================================
  // Compare, wait and drive helpers
  task automatic chk8(input logic [7:0] a, input logic [7:0] e);
    n_tests++;
    if (a !== e)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic chk1(input logic a, input logic e);
    chk8({7'h00, a}, {7'h00, e});
  endtask
  task automatic wait_irq;
    int n;
    begin
      n = 0;
      while (irq !== 1'b1 && n < 12)
      begin
        @(posedge ref_clk_i) #1;
        n++;
      end
    end
  endtask
  task automatic set_in(input logic [7:0] v);
    @(posedge ref_clk_i) #1;
    mon = v;
  endtask
  task automatic close_out;
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_change;
    set_in(8'hA5);
    wait_irq();
    chk1(irq, 1'b1);
    host_model_i.do_read(1'b0, d, ok);
    chk1(ok, 1'b1);
    chk8(d, 8'hA5);
    chk1(irq, 1'b0);
    chk1(oe, 1'b0);
  endtask
  task automatic t_pending;
    set_in(8'h24);
    wait_irq();
    chk1(irq, 1'b1);
    set_in(8'h3C);
    repeat (6) @(posedge ref_clk_i);
    host_model_i.do_read(1'b0, d, ok);
    chk8(d, 8'h24);
    chk1(irq, 1'b1);
    host_model_i.do_read(1'b0, d, ok);
    chk8(d, 8'h3C);
    chk1(irq, 1'b0);
  endtask
  task automatic t_live;
    set_in(8'h5A);
    wait_irq();
    host_model_i.do_read(1'b1, d, ok);
    chk8(d, 8'h5A);
    chk1(irq, 1'b1);
    host_model_i.do_read(1'b0, d, ok);
    chk8(d, 8'h5A);
    chk1(irq, 1'b0);
  endtask
  task automatic t_idle;
    set_in(8'hFF);
    repeat (10)
    begin
      @(posedge ref_clk_i) #1;
      chk1(oe, 1'b0);
    end
    chk1(irq, 1'b1);
    host_model_i.do_read(1'b0, d, ok);
    chk8(d, 8'hFF);
    // Falling edges only
    set_in(8'h00);
    wait_irq();
    chk1(irq, 1'b1);
    host_model_i.do_read(1'b0, d, ok);
    chk8(d, 8'h00);
    chk1(irq, 1'b0);
  endtask
  // Reset in mid-run with a change pending, then a fresh capture
  task automatic t_reset;
    set_in(8'h81);
    wait_irq();
    @(posedge ref_clk_i) #1;
    rst_n_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    chk1(irq, 1'b0);
    chk1(oe, 1'b0);
    wait_irq();
    chk1(irq, 1'b1);
    host_model_i.do_read(1'b0, d, ok);
    chk8(d, 8'h81);
    chk1(irq, 1'b0);
  endtask
  // Main sequence
  initial
  begin
    miscompares = 0;
    n_tests     = 0;
    mon         = 8'h00;
    rst_n_i     = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    chk1(irq, 1'b0);
    t_change();
    t_pending();
    t_live();
    t_idle();
    t_reset();
    close_out();
  end
  // Watchdog
  initial
  begin
    #20000;
    miscompares++;
    close_out();
  end
endmodule
